// ===== rtl/atf_mem.sv
`timescale 1ns/1ns
// ******************************************************
// Result storage, registered read data
// ******************************************************
module atf_mem (
   input wire logic aclk,
   atf_mem_if.mem   mif
);
   logic [atf_pkg::DW-1:0] ram [atf_pkg::FIFO_DEPTH];

   // Write and registered read
   always_ff @(posedge aclk) begin
      if (mif.wr_en) begin
         ram[mif.wr_addr] <= mif.wr_data;
      end
      if (mif.rd_en) begin
         mif.rd_data <= ram[mif.rd_addr];
      end
   end
endmodule : atf_mem

// ===== rtl/atf_mem_if.sv
`timescale 1ns/1ns
// ******************************************************
// FIFO storage port group
// ******************************************************
interface atf_mem_if;
   logic                      wr_en;
   logic [atf_pkg::PW-1:0]    wr_addr;
   logic [atf_pkg::DW-1:0]    wr_data;
   logic                      rd_en;
   logic [atf_pkg::PW-1:0]    rd_addr;
   logic [atf_pkg::DW-1:0]    rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : atf_mem_if

// ===== rtl/atf_pkg.sv
package atf_pkg;
   // ******************************************************
   // Timing
   // ******************************************************
   localparam int unsigned CLK_HZ       = 20000000;
   localparam real         CONV_TIME_US = 8.5;
   localparam int unsigned CONV_CYCLES  = $rtoi(CONV_TIME_US * real'(CLK_HZ) / 1.0e6);
   localparam int unsigned CONV_CW      = 8;
   localparam logic [7:0]  CONV_LOAD    = 8'(CONV_CYCLES - 2);

   // ******************************************************
   // FIFO geometry
   // ******************************************************
   localparam int unsigned DW         = 16;
   localparam int unsigned FIFO_DEPTH = 1024;
   localparam int unsigned PW         = 10;
   localparam int unsigned CW         = 11;
   localparam logic [10:0] FIFO_FULL  = 11'h400;
   localparam logic [10:0] FIFO_HALF  = 11'h200;

   // ******************************************************
   // Register map (byte addresses)
   // ******************************************************
   localparam int unsigned AXW      = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_SWTR = 12'h004;
   localparam logic [11:0] OFS_STAT = 12'h008;
   localparam logic [11:0] OFS_DATA = 12'h00C;
   localparam logic [11:0] OFS_CHAN = 12'h010;
   localparam logic [11:0] OFS_DIV0 = 12'h014;
   localparam logic [11:0] OFS_DIV1 = 12'h018;
   localparam logic [11:0] OFS_CLR  = 12'h01C;

   // Control fields
   localparam int unsigned CTL_EXT   = 0;
   localparam int unsigned CTL_PACER = 1;
   localparam int unsigned CTL_SCAN  = 2;
   localparam int unsigned CTL_ISRC  = 3;
   localparam int unsigned CTL_IEN   = 4;
   // Status fields
   localparam int unsigned STA_AVAIL = 0;
   localparam int unsigned STA_IDLE  = 1;
   localparam int unsigned STA_HALF  = 2;
   localparam int unsigned STA_FULL  = 3;
   localparam int unsigned STA_OVR   = 4;
   localparam int unsigned STA_IRQ   = 5;
   localparam int unsigned STA_CNT   = 16;
   // Clear fields
   localparam int unsigned CLR_IRQ   = 0;
   localparam int unsigned CLR_OVR   = 1;

   // Reset values
   localparam logic [4:0]  CTRL_RST = 5'h00;
   localparam logic [7:0]  CHAN_RST = 8'h00;
   localparam logic [15:0] DIV_RST  = 16'h0014;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {ATF_CNV_IDLE = 1'b0, ATF_CNV_BUSY = 1'b1} atf_cnv_e;
endpackage : atf_pkg

// ===== rtl/atf_top.sv
`timescale 1ns/1ns
module atf_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        external_trigger_input,
   input  wire logic [15:0] adc_data,
   output logic             adc_start,
   output logic [3:0]       adc_channel,
   output logic             first_interrupt_request
);
   // Trigger cycle to result write, derived from the shared cycle count
   localparam int CONV_DLY = int'(atf_pkg::CONV_CYCLES) - 1;

   // ******************************************************
   // Declarations
   // ******************************************************
   logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
   logic [11:0] aw_addr_r, aw_addr_nxt, rd_addr_r, rd_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt, wmask, rd_word;
   logic [3:0]  w_strb_r, w_strb_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic        rd_pend_r, rd_pend_nxt, rd_pop_r, rd_pop_nxt, rvalid_r, rvalid_nxt;
   logic        wr_do, ar_hs, wr_hit, rd_hit;
   logic [4:0]  ctrl_r, ctrl_nxt;
   logic [7:0]  mux_r, mux_nxt;
   logic [15:0] div0_r, div0_nxt, div1_r, div1_nxt, p0_r, p0_nxt, p1_r, p1_nxt;
   logic        ext_sel, pacer_sel, scan_on, sw_wr, pacer_fire, ext_fall, trig;
   logic        ext_prev_r, conv_start, push_req, push, pop, half_evt, clr_irq, clr_ovr;
   atf_pkg::atf_cnv_e cnv_r, cnv_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [3:0]  chan_r, chan_nxt;
   logic [9:0]  wp_r, wp_nxt, rp_r, rp_nxt;
   logic [10:0] count_r, count_nxt;
   logic        full, empty, half_full, ovr_r, ovr_nxt, irq_r, irq_nxt, adc_start_r;

   atf_mem_if mif ();

   atf_mem u_mem (
      .aclk (aclk),
      .mif  (mif)
   );

   // ******************************************************
   // AXI4-Lite slave
   // ******************************************************
   // Handshakes and byte-lane mask
   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready  = !w_got_r && !bvalid_r;
   assign s_axi_arready = !rd_pend_r && !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign wr_do = aw_got_r && w_got_r && !bvalid_r;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign wr_hit = aw_addr_r[11:5] == 7'h00 && aw_addr_r[1:0] == 2'h0;
   assign rd_hit = rd_addr_r[11:5] == 7'h00 && rd_addr_r[1:0] == 2'h0;

   // Read word mux
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (rd_addr_r)
         atf_pkg::OFS_CTRL: rd_word = {27'h000_0000, ctrl_r};
         atf_pkg::OFS_STAT: begin
            rd_word = {5'h00, count_r, 10'h000, irq_r, ovr_r, full, half_full,
                       cnv_r == atf_pkg::ATF_CNV_IDLE, !empty};
         end
         atf_pkg::OFS_DATA: rd_word = rd_pop_r ? {16'h0000, mif.rd_data} : 32'h0000_0000;
         atf_pkg::OFS_CHAN: rd_word = {20'h0_0000, adc_channel, mux_r};
         atf_pkg::OFS_DIV0: rd_word = {16'h0000, div0_r};
         atf_pkg::OFS_DIV1: rd_word = {16'h0000, div1_r};
         default:           rd_word = 32'h0000_0000;
      endcase
   end

   // Bus channel next state
   always_comb begin
      aw_got_nxt  = aw_got_r;
      aw_addr_nxt = aw_addr_r;
      w_got_nxt   = w_got_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r && !s_axi_bready;
      bresp_nxt   = bresp_r;
      rd_pend_nxt = ar_hs;
      rd_addr_nxt = ar_hs ? s_axi_araddr : rd_addr_r;
      rd_pop_nxt  = ar_hs ? pop : rd_pop_r;
      rvalid_nxt  = rd_pend_r || (rvalid_r && !s_axi_rready);
      rdata_nxt   = rd_pend_r ? rd_word : rdata_r;
      rresp_nxt   = rd_pend_r ? (rd_hit ? atf_pkg::RESP_OKAY : atf_pkg::RESP_SLVERR) : rresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_nxt  = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_nxt  = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (wr_do) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = wr_hit ? atf_pkg::RESP_OKAY : atf_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r  <= 1'b0;
         aw_addr_r <= 12'h000;
         w_got_r   <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
         rd_pend_r <= 1'b0;
         rd_addr_r <= 12'h000;
         rd_pop_r  <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= 2'h0;
      end else begin
         aw_got_r  <= aw_got_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_got_r   <= w_got_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rd_pend_r <= rd_pend_nxt;
         rd_addr_r <= rd_addr_nxt;
         rd_pop_r  <= rd_pop_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // ******************************************************
   // Configuration registers
   // ******************************************************
   // Trigger, scan and interrupt fields; external source overrides pacer, pacer overrides software
   assign ext_sel   = ctrl_r[atf_pkg::CTL_EXT];
   assign pacer_sel = ctrl_r[atf_pkg::CTL_PACER];
   assign scan_on   = ctrl_r[atf_pkg::CTL_SCAN];
   assign sw_wr     = wr_do && aw_addr_r == atf_pkg::OFS_SWTR;
   assign clr_irq   = wr_do && aw_addr_r == atf_pkg::OFS_CLR && w_strb_r[0]
                      && w_data_r[atf_pkg::CLR_IRQ];
   assign clr_ovr   = wr_do && aw_addr_r == atf_pkg::OFS_CLR && w_strb_r[0]
                      && w_data_r[atf_pkg::CLR_OVR];

   always_comb begin
      ctrl_nxt = ctrl_r;
      mux_nxt  = mux_r;
      div0_nxt = div0_r;
      div1_nxt = div1_r;
      if (wr_do && w_strb_r[0]) begin
         if (aw_addr_r == atf_pkg::OFS_CTRL) ctrl_nxt = w_data_r[4:0];
         if (aw_addr_r == atf_pkg::OFS_CHAN) mux_nxt = w_data_r[7:0];
      end
      if (wr_do && aw_addr_r == atf_pkg::OFS_DIV0) begin
         div0_nxt = (div0_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
      end
      if (wr_do && aw_addr_r == atf_pkg::OFS_DIV1) begin
         div1_nxt = (div1_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= atf_pkg::CTRL_RST;
         mux_r  <= atf_pkg::CHAN_RST;
         div0_r <= atf_pkg::DIV_RST;
         div1_r <= atf_pkg::DIV_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         mux_r  <= mux_nxt;
         div0_r <= div0_nxt;
         div1_r <= div1_nxt;
      end
   end

   // ******************************************************
   // Trigger selection and pacer
   // ******************************************************
   // Cascaded pacer counters, run only when pacer is the source
   assign ext_fall   = ext_prev_r && !external_trigger_input;
   assign pacer_fire = !ext_sel && pacer_sel && p0_r >= div0_r - 16'h0001
                       && p1_r >= div1_r - 16'h0001;
   assign trig       = ext_sel ? ext_fall : (pacer_sel ? pacer_fire : sw_wr);
   assign conv_start = trig && cnv_r == atf_pkg::ATF_CNV_IDLE;

   always_comb begin
      p0_nxt = 16'h0000;
      p1_nxt = 16'h0000;
      if (!ext_sel && pacer_sel) begin
         p0_nxt = p0_r + 16'h0001;
         p1_nxt = p1_r;
         if (p0_r >= div0_r - 16'h0001) begin
            p0_nxt = 16'h0000;
            p1_nxt = (p1_r >= div1_r - 16'h0001) ? 16'h0000 : p1_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p0_r       <= 16'h0000;
         p1_r       <= 16'h0000;
         ext_prev_r <= 1'b1;
      end else begin
         p0_r       <= p0_nxt;
         p1_r       <= p1_nxt;
         ext_prev_r <= external_trigger_input;
      end
   end

   property p_ext_only;
      @(posedge aclk) disable iff (!aresetn)
      ext_sel && !ext_fall |-> !conv_start;
   endproperty
   a_ext_only: assert property (p_ext_only) else $error("internal trigger with external source");
   property p_sw_trig;
      @(posedge aclk) disable iff (!aresetn)
      !ext_sel && !pacer_sel && sw_wr && cnv_r == atf_pkg::ATF_CNV_IDLE |-> conv_start;
   endproperty
   a_sw_trig: assert property (p_sw_trig) else $error("software write did not trigger");
   property p_pacer;
      @(posedge aclk) disable iff (!aresetn)
      pacer_fire && cnv_r == atf_pkg::ATF_CNV_IDLE |-> conv_start ##1 !pacer_fire;
   endproperty
   a_pacer: assert property (p_pacer) else $error("pacer pulse did not trigger");
   property p_ext_edge;
      @(posedge aclk) disable iff (!aresetn)
      ext_sel && $fell(external_trigger_input) && cnv_r == atf_pkg::ATF_CNV_IDLE
      |-> conv_start ##1 adc_start;
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("falling edge did not trigger");

   // ******************************************************
   // Conversion and channel scan
   // ******************************************************
   assign push_req  = cnv_r == atf_pkg::ATF_CNV_BUSY && cnt_r == 8'h00;
   assign adc_start = adc_start_r;
   assign adc_channel = scan_on ? chan_r : mux_r[3:0];

   always_comb begin
      cnv_nxt  = cnv_r;
      cnt_nxt  = cnt_r;
      chan_nxt = scan_on ? chan_r : 4'h0;
      // Advance only after the started conversion has taken its channel
      if (scan_on && adc_start_r) begin
         chan_nxt = (chan_r == mux_r[3:0]) ? 4'h0 : chan_r + 4'h1;
      end
      unique case (cnv_r)
         atf_pkg::ATF_CNV_IDLE: if (conv_start) begin
            cnv_nxt = atf_pkg::ATF_CNV_BUSY;
            cnt_nxt = atf_pkg::CONV_LOAD;
         end
         atf_pkg::ATF_CNV_BUSY: begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h00) cnv_nxt = atf_pkg::ATF_CNV_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnv_r       <= atf_pkg::ATF_CNV_IDLE;
         cnt_r       <= 8'h00;
         chan_r      <= 4'h0;
         adc_start_r <= 1'b0;
      end else begin
         cnv_r       <= cnv_nxt;
         cnt_r       <= cnt_nxt;
         chan_r      <= chan_nxt;
         adc_start_r <= conv_start;
      end
   end

   sequence s_busy8;
      cnv_r == atf_pkg::ATF_CNV_BUSY [*8];
   endsequence
   property p_busy;
      @(posedge aclk) disable iff (!aresetn)
      conv_start |=> s_busy8;
   endproperty
   a_busy: assert property (p_busy) else $error("idle flag high during conversion");
   property p_conv_time;
      @(posedge aclk) disable iff (!aresetn)
      conv_start |-> ##CONV_DLY push_req;
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("result not ready in time");
   property p_scan_wrap;
      @(posedge aclk) disable iff (!aresetn)
      scan_on && adc_start && chan_r == mux_r[3:0] ##1 scan_on |-> adc_channel == 4'h0;
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap to zero");

   // ******************************************************
   // FIFO control, status and interrupt
   // ******************************************************
   assign full      = count_r == atf_pkg::FIFO_FULL;
   assign empty     = count_r == 11'h000;
   assign half_full = count_r >= atf_pkg::FIFO_HALF;
   assign push      = push_req && !full;
   assign pop       = ar_hs && s_axi_araddr == atf_pkg::OFS_DATA && !empty;
   assign half_evt  = count_nxt == atf_pkg::FIFO_HALF && count_r != atf_pkg::FIFO_HALF;
   assign first_interrupt_request = irq_r;
   assign mif.wr_en   = push;
   assign mif.wr_addr = wp_r;
   assign mif.wr_data = adc_data;
   assign mif.rd_en   = pop;
   assign mif.rd_addr = rp_r;

   always_comb begin
      wp_nxt    = push ? wp_r + 10'h001 : wp_r;
      rp_nxt    = pop ? rp_r + 10'h001 : rp_r;
      count_nxt = count_r + {10'h000, push} - {10'h000, pop};
      ovr_nxt   = (ovr_r && !clr_ovr) || (push_req && full);
      irq_nxt   = (irq_r && !clr_irq) || (ctrl_r[atf_pkg::CTL_IEN]
                  && (ctrl_r[atf_pkg::CTL_ISRC] ? half_evt : push));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_r    <= 10'h000;
         rp_r    <= 10'h000;
         count_r <= 11'h000;
         ovr_r   <= 1'b0;
         irq_r   <= 1'b0;
      end else begin
         wp_r    <= wp_nxt;
         rp_r    <= rp_nxt;
         count_r <= count_nxt;
         ovr_r   <= ovr_nxt;
         irq_r   <= irq_nxt;
      end
   end

   property p_discard;
      @(posedge aclk) disable iff (!aresetn)
      push_req && full && !pop |=> full && ovr_r;
   endproperty
   a_discard: assert property (p_discard) else $error("write into full FIFO");
   property p_avail;
      @(posedge aclk) disable iff (!aresetn)
      push_req && !full |=> !empty && count_r == $past(count_r) + 11'h001 - {10'h000, $past(pop)};
   endproperty
   a_avail: assert property (p_avail) else $error("result not stored");
   property p_eoc_irq;
      @(posedge aclk) disable iff (!aresetn)
      ctrl_r[atf_pkg::CTL_IEN] && !ctrl_r[atf_pkg::CTL_ISRC] && push |=> irq_r && !empty;
   endproperty
   a_eoc_irq: assert property (p_eoc_irq) else $error("missing conversion interrupt");
   property p_half_irq;
      @(posedge aclk) disable iff (!aresetn)
      ctrl_r[atf_pkg::CTL_IEN] && ctrl_r[atf_pkg::CTL_ISRC] && count_r == 11'h1FF
      && push && !pop |=> irq_r && half_full;
   endproperty
   a_half_irq: assert property (p_half_irq) else $error("missing half-full interrupt");
endmodule : atf_top

// ===== tb/adc_trigger_fifo_control_test.sv
`timescale 1ns/1ns
module adc_trigger_fifo_control_test;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, external_trigger_input, adc_start, first_interrupt_request;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] adc_data;
   logic [3:0]  s_axi_wstrb, adc_channel;
   logic [3:0]  ch [4];
   int          err_total, tests_run;

   atf_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_trigger_input,
      .adc_data, .adc_start, .adc_channel, .first_interrupt_request);
   atf_adc_model u_adc (.aclk, .adc_start, .adc_channel, .adc_data);

   // ************************************************
   // Clock, checking and bus tasks
   // ************************************************
   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   task automatic lim(input int n);
      if (n >= 50) begin
         err_total++;
         tally_and_finish();
      end
   endtask : lim

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int   n;
      logic aw_ok, w_ok, b_ok;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      b_ok = 1'h0;
      // Handshakes sampled mid-cycle, acted on at the following rising edge
      for (n = 0; n < 50 && !b_ok; n++) begin
         @(negedge aclk);
         aw_ok = s_axi_awvalid && s_axi_awready;
         w_ok  = s_axi_wvalid && s_axi_wready;
         b_ok  = s_axi_bvalid;
         rsp   = s_axi_bresp;
         @(posedge aclk);
         if (aw_ok) s_axi_awvalid <= 1'h0;
         if (w_ok) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      lim(b_ok ? 0 : 50);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      int   n;
      logic ar_ok, r_ok;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      r_ok = 1'h0;
      // Address dropped only at the edge where it was taken
      for (n = 0; n < 50 && !r_ok; n++) begin
         @(negedge aclk);
         ar_ok = s_axi_arvalid && s_axi_arready;
         r_ok  = s_axi_rvalid;
         rd_v  = s_axi_rdata;
         rsp   = s_axi_rresp;
         @(posedge aclk);
         if (ar_ok) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      lim(r_ok ? 0 : 50);
   endtask : rd

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic sc_reset;
      rd(atf_pkg::OFS_CTRL);
      chk(rd_v, 32'h0000_0000);
      rd(atf_pkg::OFS_STAT);
      chk(rd_v, 32'h0000_0002);
   endtask : sc_reset

   task automatic sc_soft;
      wr(atf_pkg::OFS_SWTR, 32'hDEAD_BEEF);
      rd(atf_pkg::OFS_STAT);
      chk(rd_v, 32'h0000_0000);
      repeat (166) @(posedge aclk);
      rd(atf_pkg::OFS_DATA);
      chk(rd_v, 32'h0000_A5C0);
      rd(atf_pkg::OFS_STAT);
      chk(rd_v, 32'h0000_0002);
   endtask : sc_soft

   task automatic sc_irq;
      wr(atf_pkg::OFS_CTRL, 32'h0000_0010);
      wr(atf_pkg::OFS_SWTR, 32'h0000_0000);
      @(negedge aclk);
      chk({31'h0, first_interrupt_request}, 32'h0000_0000);
      repeat (170) @(negedge aclk);
      chk({31'h0, first_interrupt_request}, 32'h0000_0001);
      rd(atf_pkg::OFS_DATA);
      wr(atf_pkg::OFS_CLR, 32'h0000_0001);
      @(negedge aclk);
      chk({31'h0, first_interrupt_request}, 32'h0000_0000);
   endtask : sc_irq

   task automatic sc_ext;
      wr(atf_pkg::OFS_CTRL, 32'h0000_0001);
      wr(atf_pkg::OFS_SWTR, 32'h0000_0000);
      repeat (175) @(posedge aclk);
      rd(atf_pkg::OFS_STAT);
      chk(rd_v, 32'h0000_0002);
      external_trigger_input <= 1'h0;
      repeat (175) @(posedge aclk);
      external_trigger_input <= 1'h1;
      rd(atf_pkg::OFS_DATA);
      chk(rd_v, 32'h0000_A5C0);
      repeat (175) @(posedge aclk);
      rd(atf_pkg::OFS_STAT);
      chk(rd_v, 32'h0000_0002);
   endtask : sc_ext

   task automatic sc_scan;
      wr(atf_pkg::OFS_CHAN, 32'h0000_0002);
      wr(atf_pkg::OFS_CTRL, 32'h0000_0004);
      for (int i = 0; i < 4; i++) begin
         wr(atf_pkg::OFS_SWTR, 32'h0000_0000);
         repeat (170) @(posedge aclk);
         rd(atf_pkg::OFS_DATA);
         ch[i] = rd_v[3:0];
      end
      chk({28'h0, ch[0]}, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         chk({28'h0, ch[i+1]}, (ch[i] == 4'h2) ? 32'h0 : {28'h0, ch[i] + 4'h1});
      end
   endtask : sc_scan

   task automatic sc_pacer;
      wr(atf_pkg::OFS_CTRL, 32'h0000_0000);
      wr(atf_pkg::OFS_DIV1, 32'h0000_000A);
      wr(atf_pkg::OFS_CTRL, 32'h0000_0002);
      repeat (1000) @(posedge aclk);
      wr(atf_pkg::OFS_CTRL, 32'h0000_0000);
      repeat (180) @(posedge aclk);
      rd(atf_pkg::OFS_STAT);
      chk({31'h0, rd_v[26:16] >= 11'h4 && rd_v[26:16] <= 11'h6}, 32'h1);
      rd(12'h020);
      chk({30'h0, rsp}, {30'h0, atf_pkg::RESP_SLVERR});
   endtask : sc_pacer

   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 57'h0;
      external_trigger_input = 1'h1;
      s_axi_wstrb = 4'hF;
      err_total = 0;
      tests_run = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      sc_reset();
      sc_soft();
      sc_irq();
      sc_ext();
      sc_scan();
      sc_pacer();
      tally_and_finish();
   end
endmodule : adc_trigger_fifo_control_test

// ===== tb/atf_adc_model.sv
`timescale 1ns/1ns
// ************************************************
// Converter model
// ************************************************
module atf_adc_model (
   input  wire logic        aclk,
   input  wire logic        adc_start,
   input  wire logic [3:0]  adc_channel,
   output logic      [15:0] adc_data
);
   logic [15:0] val_r = 16'h0000;
   logic [7:0]  busy_r = 8'h00;
   // Result tagged with its channel, valid only while converting
   always_ff @(posedge aclk) begin
      if (adc_start) begin
         val_r  <= {12'hA5C, adc_channel};
         busy_r <= 8'hAF;
      end else if (busy_r != 8'h00) begin
         busy_r <= busy_r - 8'h01;
      end
   end
   assign adc_data = (busy_r != 8'h00) ? val_r : ~val_r;
endmodule : atf_adc_model
